//--- design/event_output_action_unit.v
/*
  event output action unit: masked digital output actions (invert, pulse, write)
  and an analog output formed as gain * source + offset from a selected positioner.
  assumes positions/velocities and events come from logic on the same clock;
  software programs the action over a simple strobe register port.
*/
// Decided for this implementation: the address-and-strobe port and the register offsets.
// Operation
// - invert masked output bits, others unchanged
// - repeat invert every profiler cycle while held
// - mask bit n selects output bit n
// - pulse masked bits high for one microsecond
// - new pulse each profiler cycle while held
// - write value into masked bits only
// - analog equals position times gain plus offset
// - source actual or setpoint position per variant
// - refresh analog each servo cycle while held
// - instantaneous event updates analog once, holds
// - analog equals velocity times gain plus offset
// - offset added to cancel existing output voltage
// - servo tick runs at ten kilohertz
// - every action carries four parameter slots
// - event end never undoes the action
`timescale 1ns/10ps
`include "event_output_action_unit_consts.vh"
module event_output_action_unit #(
  parameter NPOS = 4,
  parameter PW = 16,
  parameter GW = 16,
  parameter FRAC = 8,
  parameter DW = 16,
  parameter integer SERVO_CYC = `SERVO_CYC,
  parameter integer PROFILER_CYC = `PROFILER_CYC
) (
  // clock, reset, enable
  input wire I_CLK_SYS,
  input wire I_RST_N,
  input wire I_CE,
  // register port
  input wire [3:0] I_ADDR,
  input wire [31:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [31:0] O_RDATA,
  // motion data, same clock domain
  input wire [NPOS*PW-1:0] I_ACT_POS,
  input wire [NPOS*PW-1:0] I_TGT_POS,
  input wire [NPOS*PW-1:0] I_ACT_VEL,
  input wire [NPOS*PW-1:0] I_TGT_VEL,
  // events from the profiler
  input wire I_EVENT_INSTANT,
  input wire I_EVENT_HELD,
  // outputs
  output wire [7:0] O_DOUT,
  output wire signed [DW-1:0] O_AOUT,
  output wire O_PROFILER_TICK,
  output wire O_SERVO_TICK
);
  localparam integer PULSE_CYC = `PULSE_CYC;
  localparam [31:0] PULSE_LAST = PULSE_CYC - 1;
  localparam [31:0] SERVO_LAST = SERVO_CYC - 1;
  localparam [31:0] PROF_LAST = PROFILER_CYC - 1;
  localparam integer AW = PW + GW + 2;
  localparam signed [AW-1:0] AMAX = (1 <<< (DW + FRAC - 1)) - 1;
  localparam signed [AW-1:0] AMIN = -(1 <<< (DW + FRAC - 1));

  // software side state
  reg [2:0] action_q;
  reg [31:0] param_q [0:3];
  reg armed_q;
  reg fire_q;
  reg [31:0] rdata_d;
  integer k;

  // output side state
  reg [7:0] level_q;
  reg [7:0] level_d;
  wire [7:0] pulse_on;
  reg signed [DW-1:0] aout_q;
  reg [31:0] servo_cnt_q;
  reg [31:0] prof_cnt_q;

  // analog datapath
  reg signed [PW-1:0] src;
  reg signed [AW-1:0] clamped;

  function is_digital_code;
    input [2:0] code;
    begin
      case (code)
        `ACT_INVERT: is_digital_code = 1'b1;
        `ACT_PULSE: is_digital_code = 1'b1;
        `ACT_WRITE: is_digital_code = 1'b1;
        default: is_digital_code = 1'b0;
      endcase
    end
  endfunction

  function is_analog_code;
    input [2:0] code;
    begin
      case (code)
        `ACT_ANA_ACT_POS: is_analog_code = 1'b1;
        `ACT_ANA_TGT_POS: is_analog_code = 1'b1;
        `ACT_ANA_ACT_VEL: is_analog_code = 1'b1;
        `ACT_ANA_TGT_VEL: is_analog_code = 1'b1;
        default: is_analog_code = 1'b0;
      endcase
    end
  endfunction

  function signed [PW-1:0] pick;
    input [NPOS*PW-1:0] bus;
    input [1:0] sel;
    begin
      pick = bus[sel*PW +: PW];
    end
  endfunction

  wire servo_tick = (servo_cnt_q == SERVO_LAST);
  wire prof_tick = (prof_cnt_q == PROF_LAST);
  assign O_SERVO_TICK = servo_tick;
  assign O_PROFILER_TICK = prof_tick;

  // servo pacing at ten kilohertz
  always @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      servo_cnt_q <= 32'h0;
    end else if (I_CE) begin
      if (servo_tick) begin
        servo_cnt_q <= 32'h0;
      end else begin
        servo_cnt_q <= servo_cnt_q + 32'h1;
      end
    end
  end

  // profiler pacing, one digital action per cycle for held events
  always @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      prof_cnt_q <= 32'h0;
    end else if (I_CE) begin
      if (prof_tick) begin
        prof_cnt_q <= 32'h0;
      end else begin
        prof_cnt_q <= prof_cnt_q + 32'h1;
      end
    end
  end

  // an instant event or software fire acts once; held event acts per cycle
  wire act_dig = is_digital_code(action_q);
  wire act_ana = is_analog_code(action_q);
  wire once = armed_q && (I_EVENT_INSTANT || fire_q);
  wire dig_go = act_dig && (once || (armed_q && I_EVENT_HELD && prof_tick));
  wire ana_go = act_ana && (once || (armed_q && I_EVENT_HELD && servo_tick));
  wire do_invert = dig_go && (action_q == `ACT_INVERT);
  wire do_pulse = dig_go && (action_q == `ACT_PULSE);
  wire do_write = dig_go && (action_q == `ACT_WRITE);

  wire [7:0] mask = param_q[0][7:0];
  wire [7:0] wval = param_q[1][7:0];
  wire [1:0] pos_sel = param_q[0][1:0];

  always @* begin
    case (action_q)
      `ACT_ANA_ACT_POS: begin
        src = pick(I_ACT_POS, pos_sel);
      end
      `ACT_ANA_TGT_POS: begin
        src = pick(I_TGT_POS, pos_sel);
      end
      `ACT_ANA_ACT_VEL: begin
        src = pick(I_ACT_VEL, pos_sel);
      end
      `ACT_ANA_TGT_VEL: begin
        src = pick(I_TGT_VEL, pos_sel);
      end
      default: begin
        src = {PW{1'b0}};
      end
    endcase
  end

  // gain in fixed point with FRAC fraction bits; offset in output lsb
  wire signed [GW-1:0] gain = param_q[1][GW-1:0];
  wire signed [DW-1:0] offs = param_q[2][DW-1:0];
  wire signed [PW+GW-1:0] prod = src * gain;
  // a bare concatenation is unsigned and would break negative products
  wire signed [AW-1:0] offs_ext = $signed({{(AW-DW){offs[DW-1]}}, offs});
  wire signed [AW-1:0] offs_scaled = offs_ext <<< FRAC;
  wire signed [AW-1:0] prod_ext = $signed({{2{prod[PW+GW-1]}}, prod});
  wire signed [AW-1:0] sum = prod_ext + offs_scaled;

  // saturate rather than wrap, so a large product cannot flip the sign
  always @* begin
    if (sum > AMAX) begin
      clamped = AMAX;
    end else if (sum < AMIN) begin
      clamped = AMIN;
    end else begin
      clamped = sum;
    end
  end
  wire signed [DW-1:0] ana_val = clamped[DW+FRAC-1:FRAC];

  always @* begin
    level_d = level_q;
    if (do_invert) begin
      level_d = level_q ^ mask;
    end else if (do_write) begin
      level_d = (level_q & ~mask) | (wval & mask);
    end
  end

  // outputs keep their level when the event ends; only new actions change them
  always @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      level_q <= 8'h00;
    end else if (I_CE) begin
      level_q <= level_d;
    end
  end

  always @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      aout_q <= {DW{1'b0}};
    end else if (I_CE) begin
      if (ana_go) begin
        aout_q <= ana_val;
      end
    end
  end

  // per-bit pulse timers; a retrigger restarts the count
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_pulse
      reg on_q;
      reg [31:0] cnt_q;
      assign pulse_on[g] = on_q;
      always @(posedge I_CLK_SYS) begin
        if (!I_RST_N) begin
          on_q <= 1'b0;
          cnt_q <= 32'h0;
        end else if (I_CE) begin
          if (do_pulse && mask[g]) begin
            on_q <= 1'b1;
            cnt_q <= 32'h0;
          end else if (on_q) begin
            if (cnt_q == PULSE_LAST) begin
              on_q <= 1'b0;
            end
            cnt_q <= cnt_q + 32'h1;
          end
        end
      end
    end
  endgenerate

  // pulse rides on the stored level; meaningful only from a low level
  assign O_DOUT = level_q | pulse_on;
  assign O_AOUT = aout_q;

  // register writes
  always @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      action_q <= `ACT_NONE;
      for (k = 0; k < 4; k = k + 1) begin
        param_q[k] <= 32'h0;
      end
      armed_q <= 1'b0;
      fire_q <= 1'b0;
    end else if (I_CE) begin
      fire_q <= 1'b0;
      if (I_WR) begin
        case (I_ADDR)
          `REG_ACTION: begin
            action_q <= I_WDATA[2:0];
            armed_q <= I_WDATA[31];
          end
          `REG_PARAM1: begin
            param_q[0] <= I_WDATA;
          end
          `REG_PARAM2: begin
            param_q[1] <= I_WDATA;
          end
          `REG_PARAM3: begin
            param_q[2] <= I_WDATA;
          end
          `REG_PARAM4: begin
            param_q[3] <= I_WDATA;
          end
          `REG_FIRE: begin
            fire_q <= I_WDATA[0];
          end
          default: ;
        endcase
      end
    end
  end

  // read decode; data is zero whenever no read is pending
  always @* begin
    rdata_d = 32'h0;
    if (I_RD) begin
      case (I_ADDR)
        `REG_ACTION: begin
          rdata_d = {armed_q, 28'h0, action_q};
        end
        `REG_PARAM1: begin
          rdata_d = param_q[0];
        end
        `REG_PARAM2: begin
          rdata_d = param_q[1];
        end
        `REG_PARAM3: begin
          rdata_d = param_q[2];
        end
        `REG_PARAM4: begin
          rdata_d = param_q[3];
        end
        `REG_DOUT: begin
          rdata_d = {24'h0, O_DOUT};
        end
        `REG_AOUT: begin
          rdata_d = {{(32-DW){aout_q[DW-1]}}, aout_q};
        end
        `REG_STATUS: begin
          rdata_d = {22'h0, pulse_on, I_EVENT_HELD, I_EVENT_INSTANT};
        end
        default: begin
          rdata_d = 32'h0;
        end
      endcase
    end
  end

  // read data stands one cycle after the strobe
  always @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      O_RDATA <= 32'h0;
    end else if (I_CE) begin
      O_RDATA <= rdata_d;
    end
  end
endmodule // event_output_action_unit

//--- design/event_output_action_unit_consts.vh
/*
  constants for the event output action unit: register offsets, action codes, timing.
  assumes inclusion by bare name from design files.
*/
`ifndef EVENT_OUTPUT_ACTION_UNIT_CONSTS_VH
`define EVENT_OUTPUT_ACTION_UNIT_CONSTS_VH
`define REG_ACTION 4'h0
`define REG_PARAM1 4'h1
`define REG_PARAM2 4'h2
`define REG_PARAM3 4'h3
`define REG_PARAM4 4'h4
`define REG_FIRE 4'h5
`define REG_DOUT 4'h6
`define REG_AOUT 4'h7
`define REG_STATUS 4'h8
`define ACT_NONE 3'h0
`define ACT_INVERT 3'h1
`define ACT_PULSE 3'h2
`define ACT_WRITE 3'h3
`define ACT_ANA_ACT_POS 3'h4
`define ACT_ANA_TGT_POS 3'h5
`define ACT_ANA_ACT_VEL 3'h6
`define ACT_ANA_TGT_VEL 3'h7
`define CLK_MHZ 125
`define PULSE_US 1
`define PULSE_CYC (`PULSE_US * `CLK_MHZ)
`define SERVO_KHZ 10
`define SERVO_CYC ((`CLK_MHZ * 1000) / `SERVO_KHZ)
`define PROFILER_US 400
`define PROFILER_CYC (`PROFILER_US * `CLK_MHZ)
`endif

//--- sim/eoau_asserts.sv
/* port checker for the event output action unit
   assumes bind from the bench with its short tick counts */
`timescale 1ns/10ps
module eoau_asserts #(parameter int SERVO_CYC = 10, parameter int PROFILER_CYC = 20) (
  input wire I_CLK_SYS,
  input wire I_RST_N,
  input wire [3:0] I_ADDR,
  input wire I_WR,
  input wire I_RD,
  input wire I_EVENT_INSTANT,
  input wire I_EVENT_HELD,
  input wire [31:0] O_RDATA,
  input wire [7:0] O_DOUT,
  input wire signed [15:0] O_AOUT,
  input wire O_SERVO_TICK,
  input wire O_PROFILER_TICK
);
  // any digital rise or analog change needs a cause in the last three cycles
  wire cause = I_WR | I_EVENT_INSTANT | I_EVENT_HELD;
  default clocking cb @(posedge I_CLK_SYS); endclocking
  default disable iff (!I_RST_N);
  property p_rd_idle; !I_RD |=> O_RDATA == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not cleared");
  property p_rd_dout; I_RD && I_ADDR == 4'h6 |=> O_RDATA == {24'h0, $past(O_DOUT)}; endproperty
  a_rd_dout: assert property (p_rd_dout) else $error("digital readback wrong");
  property p_rd_aout; I_RD && I_ADDR == 4'h7 |=> O_RDATA == {{16{$past(O_AOUT[15])}}, $past(O_AOUT)}; endproperty
  a_rd_aout: assert property (p_rd_aout) else $error("analog readback wrong");
  property p_rd_none; I_RD && I_ADDR > 4'h8 |=> O_RDATA == 32'h0; endproperty
  a_rd_none: assert property (p_rd_none) else $error("unmapped read not zero");
  property p_servo; O_SERVO_TICK |-> ##SERVO_CYC O_SERVO_TICK; endproperty
  a_servo: assert property (p_servo) else $error("servo tick spacing");
  property p_prof; O_PROFILER_TICK |-> ##PROFILER_CYC O_PROFILER_TICK; endproperty
  a_prof: assert property (p_prof) else $error("profiler tick spacing");
  property p_dout_rise; |(O_DOUT & ~$past(O_DOUT)) |-> $past(cause) || $past(cause, 2) || $past(cause, 3); endproperty
  a_dout_rise: assert property (p_dout_rise) else $error("digital rise without cause");
  property p_aout_cause; $changed(O_AOUT) |-> $past(cause) || $past(cause, 2) || $past(cause, 3); endproperty
  a_aout_cause: assert property (p_aout_cause) else $error("analog change without cause");
endmodule // eoau_asserts

//--- sim/output_load.sv
/* external load on the digital outputs: times the last high run of one bit
   assumes the unit's clock */
`timescale 1ns/10ps
module output_load #(parameter int BIT = 0) (
  input wire i_clk,
  input wire [7:0] i_dout,
  output logic [15:0] o_run
);
  logic [15:0] cnt_q;
  always @(posedge i_clk) begin
    cnt_q <= i_dout[BIT] ? cnt_q + 16'h1 : 16'h0;
    if (!i_dout[BIT] && cnt_q != 16'h0)
      o_run <= cnt_q;
  end
endmodule // output_load

//--- sim/event_output_action_unit_tb.sv
/* bench of the event output action unit with a load on its outputs
   assumes servo and profiler counts shortened to 10 and 20 cycles */
`timescale 1ns/10ps
`include "event_output_action_unit_consts.vh"
module event_output_action_unit_tb;
  logic clk = 0, rst_n = 0, wr = 0, rd = 0, ev_i = 0, ev_h = 0, stick, ptick;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0, rdv, rdata;
  logic [63:0] apos = 64'h0000_0000_000A_0001, tpos = 64'h0014_0002, avel = 64'h4000_0003, tvel = 64'h0028_0004;
  logic [7:0] dout;
  logic signed [15:0] aout;
  logic [15:0] run;
  int err_total = 0, total_checks = 0, n;
  always #4 clk = ~clk;
  event_output_action_unit #(.SERVO_CYC(10), .PROFILER_CYC(20)) DUT (.I_CLK_SYS(clk), .I_RST_N(rst_n),
    .I_CE(1'b1), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata), .I_ACT_POS(apos),
    .I_TGT_POS(tpos), .I_ACT_VEL(avel), .I_TGT_VEL(tvel), .I_EVENT_INSTANT(ev_i), .I_EVENT_HELD(ev_h),
    .O_DOUT(dout), .O_AOUT(aout), .O_PROFILER_TICK(ptick), .O_SERVO_TICK(stick));
  output_load #(.BIT(0)) LOAD (.i_clk(clk), .i_dout(dout), .o_run(run));
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    rd <= 1'b0;
    @(negedge clk);
    rdv = rdata;
  endtask
  task automatic act(input logic [31:0] code, p1, p2, p3);
    bus(1, `REG_PARAM1, p1);
    bus(1, `REG_PARAM2, p2);
    bus(1, `REG_PARAM3, p3);
    bus(1, `REG_PARAM4, 32'h0);
    bus(1, `REG_ACTION, 32'h80000000 | code);
  endtask
  task automatic fire(input logic [31:0] code, p1, p2);
    act(code, p1, p2, 32'h0);
    bus(1, `REG_FIRE, 32'h1);
    repeat (4) @(posedge clk);
  endtask
  task automatic dout_is(input logic [7:0] exp);
    bus(0, `REG_DOUT, 32'h0);
    check("dout", rdv, {24'h0, exp});
  endtask
  task automatic t_digital();
    fire(`ACT_WRITE, 32'hFF, 32'h05);
    dout_is(8'h05);
    fire(`ACT_WRITE, 32'h1A, 32'h08);
    dout_is(8'h0D);
    fire(`ACT_INVERT, 32'h04, 32'h0);
    dout_is(8'h09);
    fire(`ACT_WRITE, 32'hFF, 32'h00);
    fire(`ACT_PULSE, 32'h01, 32'h0);
    repeat (130) @(posedge clk);
    check("pulse", {16'h0, run}, 32'd125);
    dout_is(8'h00);
  endtask
  task automatic t_held();
    act(`ACT_INVERT, 32'h80, 32'h0, 32'h0);
    n = 0;
    @(posedge clk);
    ev_h <= 1'b1;
    repeat (60) begin
      @(negedge clk);
      if (ptick === 1'b1 && ev_h === 1'b1)
        n++;
    end
    @(posedge clk);
    ev_h <= 1'b0;
    repeat (3) @(posedge clk);
    check("ticks", n, 3);
    dout_is({n[0], 7'h0});
  endtask
  task automatic t_analog();
    logic [31:0] exp [4] = '{32'd35, 32'd65, 32'h7FFF, 32'd125};
    for (int k = 0; k < 4; k++) begin
      act(`ACT_ANA_ACT_POS + k, 32'h1, 32'h300, 32'h5);
      @(posedge clk);
      ev_i <= 1'b1;
      @(posedge clk);
      ev_i <= 1'b0;
      repeat (3) @(posedge clk);
      check("aout", {{16{aout[15]}}, aout}, exp[k]);
    end
    tvel[31:16] <= 16'd50;
    repeat (20) @(posedge clk);
    check("hold", {16'h0, aout}, 32'd125);
    ev_h <= 1'b1;
    repeat (12) @(posedge clk);
    ev_h <= 1'b0;
    bus(0, `REG_AOUT, 32'h0);
    check("refresh", rdv, 32'd155);
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge clk);
    rst_n <= 1'b1;
    t_digital();
    t_held();
    t_analog();
    bus(0, 4'hC, 32'h0);
    check("unmapped", rdv, 32'h0);
    print_verdict();
  end
  // several times the expected run
  initial begin
    #50000;
    err_total++;
    print_verdict();
  end
endmodule // event_output_action_unit_tb
bind event_output_action_unit eoau_asserts #(.SERVO_CYC(SERVO_CYC), .PROFILER_CYC(PROFILER_CYC)) CHK (
  .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_ADDR(I_ADDR), .I_WR(I_WR), .I_RD(I_RD),
  .I_EVENT_INSTANT(I_EVENT_INSTANT), .I_EVENT_HELD(I_EVENT_HELD), .O_RDATA(O_RDATA), .O_DOUT(O_DOUT),
  .O_AOUT(O_AOUT), .O_SERVO_TICK(O_SERVO_TICK), .O_PROFILER_TICK(O_PROFILER_TICK));
